// file: hdl/iop_consts.svh
// Constants of the word assembler and multiplexer: widths, counts and timing.
`ifndef IOP_CONSTS_SVH
`define IOP_CONSTS_SVH

// ----------------------------------------------------------------
// Data shapes
// ----------------------------------------------------------------
`define IOP_NUM_ASM 4
`define IOP_XFER_W 14
`define IOP_CHAR_W 7
`define IOP_GROUP_W 12
`define IOP_WORD_W 48
`define IOP_GROUPS 4
`define IOP_UNIT_W 6
`define IOP_BLK_W 5
`define IOP_BLOCK_XFERS 515
`define IOP_FIFO_DEPTH 4

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define IOP_CLK_NS 25
`define IOP_CONT_LIMIT_NS 15000
`define IOP_CONT_LIMIT_CYC (`IOP_CONT_LIMIT_NS / `IOP_CLK_NS)
`define IOP_POLL_ALL_NS 1000
`define IOP_POLL_STEP_CYC ((`IOP_POLL_ALL_NS / `IOP_NUM_ASM) / `IOP_CLK_NS)

`endif

// file: hdl/iop_pkg.sv
// Types shared by the word assembler and multiplexer.
package iop_pkg;
	typedef enum logic [1:0] {
		IOP_MX_SCAN = 2'h0,
		IOP_MX_WAIT = 2'h1,
		IOP_MX_LOAD = 2'h3
	} iop_mux_state_type;

	typedef enum logic {
		IOP_DIR_IN = 1'b0,
		IOP_DIR_OUT = 1'b1
	} iop_dir_type;
endpackage : iop_pkg

// file: hdl/iop_word_assembler_mux.sv
// Input-output processor datapath: transfer FIFO, assembler and multiplexer top.
// How it works
// R1 - Input character pairs packed into eight-character words
// R2 - Output word split into four two-character groups
// R3 - Four independent assemblers run concurrently
// R4 - Accepted order assigns assembler, connects, signals continue
// R5 - Input transfer latched, odd parity checked, low-loaded
// R6 - Transfers counted; even channel parity checked per block
// R7 - Forward input shifts left twelve per group
// R8 - Full word copied to word register, shift cleared
// R9 - Transfer continues until block count exhausted
// R10 - Backward input loads top twelve, shifts right
// R11 - Output word shifted out top twelve at once
// R12 - Parity bit added per character, fourteen bits out
// R13 - Read-back parity checked then discarded
// R14 - Sprocket per output transfer; block mark after 515
// R15 - Output memory request after word fully sent
// R16 - Multiplexer polls requests, halts until served
// R17 - Request memory; computer grants when it chooses
// R18 - Requests held until served, fixed order
// R19 - Loaded word copied on output, cleared on input
// R20 - Computer stores transfer register back to memory
// R21 - Continue given well within fifteen microseconds
// R22 - Lowest free assembler when unit not held
// R23 - Ascending order, polling resumes after served assembler
`include "iop_consts.svh"

// ----------------------------------------------------------------
// Transfer FIFO
// ----------------------------------------------------------------
module iop_fifo #(
	parameter int WIDTH = `IOP_XFER_W,
	parameter int DEPTH = `IOP_FIFO_DEPTH
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Filling side
	input wire logic in_valid,
	input wire logic [WIDTH-1:0] in_data,
	output logic in_ready,
	// Draining side
	output logic out_valid,
	output logic [WIDTH-1:0] out_data,
	input wire logic out_ready
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_r;
	logic [AW-1:0] rd_r;
	logic [AW:0] cnt_r;
	wire push = in_valid && in_ready;
	wire pop = out_valid && out_ready;
	wire [AW-1:0] wr_inc = (wr_r == AW'(DEPTH - 1)) ? '0 : wr_r + 1'b1;
	wire [AW-1:0] rd_inc = (rd_r == AW'(DEPTH - 1)) ? '0 : rd_r + 1'b1;

	assign in_ready = cnt_r != (AW + 1)'(DEPTH);
	assign out_valid = cnt_r != '0;
	assign out_data = mem[rd_r];

	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_r] <= in_data;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			wr_r <= '0;
			rd_r <= '0;
			cnt_r <= '0;
		end else begin
			wr_r <= push ? wr_inc : wr_r;
			rd_r <= pop ? rd_inc : rd_r;
			cnt_r <= cnt_r + (AW + 1)'(push) - (AW + 1)'(pop);
		end
	end
endmodule : iop_fifo

// ----------------------------------------------------------------
// One assembler
// ----------------------------------------------------------------
module iop_assembler #(
	parameter int BLOCK_XFERS = `IOP_BLOCK_XFERS
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Order start
	input wire logic start,
	input wire logic start_dir,
	input wire logic start_back,
	input wire logic [`IOP_BLK_W-1:0] start_blocks,
	// Memory service
	input wire logic svc,
	input wire logic [`IOP_WORD_W-1:0] svc_word,
	output logic mem_need,
	output logic [`IOP_WORD_W-1:0] word_out,
	// Device data
	input wire logic in_valid,
	input wire logic [`IOP_XFER_W-1:0] in_data,
	output logic in_ready,
	output logic out_valid,
	output logic [`IOP_XFER_W-1:0] out_data,
	input wire logic out_ready,
	// Status
	output logic busy,
	output logic sprocket,
	output logic block_mark,
	output logic char_err,
	output logic chan_err
);
	import iop_pkg::*;
	logic active_r, dir_r, back_r, word_full_r, out_valid_r, sprocket_r, mark_r, char_err_r, chan_err_r;
	logic [`IOP_BLK_W-1:0] blocks_r;
	logic [`IOP_WORD_W-1:0] shift_r, word_r;
	logic [`IOP_XFER_W-1:0] out_r, chan_r;
	logic [2:0] grp_r;
	logic [9:0] xcnt_r;

	wire is_out = dir_r == IOP_DIR_OUT;
	wire more = active_r && blocks_r != '0;
	wire par_ok = (^in_data[13:7]) && (^in_data[6:0]);
	wire [`IOP_GROUP_W-1:0] data12 = {in_data[12:7], in_data[5:0]};
	wire last_xfer = xcnt_r == 10'(BLOCK_XFERS - 1);
	wire word_done = grp_r == 3'h3 || last_xfer;
	wire in_take = in_valid && in_ready;
	wire asm_in = in_take && !is_out;
	wire [`IOP_WORD_W-1:0] shift_in = back_r ? {data12, shift_r[47:12]} : {shift_r[35:0], data12}; // R7 R10
	wire out_fire = out_valid_r && out_ready;
	wire final_fire = out_fire && last_xfer && blocks_r == `IOP_BLK_W'(1);
	wire send = is_out && more && grp_r != '0 && (!out_valid_r || out_ready) && !final_fire;
	wire load_shift = is_out && more && grp_r == '0 && word_full_r;
	wire block_end = (asm_in || out_fire) && last_xfer;
	// The next word is asked for only once the last group has left, so an order never fetches past its final block.
	wire out_need = more && grp_r == '0 && !word_full_r && !out_valid_r;
	wire [5:0] hi_ch = shift_r[47:42];
	wire [5:0] lo_ch = shift_r[41:36];

	// Read-back during writing is accepted so the device is never stalled.
	assign in_ready = more && (is_out || !(word_full_r && word_done)); // R13
	assign mem_need = active_r && (is_out ? out_need : word_full_r); // R15 R18
	assign word_out = word_r;
	assign out_valid = out_valid_r;
	assign out_data = out_r;
	assign busy = active_r;
	assign sprocket = sprocket_r;
	assign block_mark = mark_r;
	assign char_err = char_err_r;
	assign chan_err = chan_err_r;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			active_r <= 1'b0;
			dir_r <= 1'b0;
			back_r <= 1'b0;
			blocks_r <= '0;
		end else if (start) begin
			active_r <= 1'b1;
			dir_r <= start_dir;
			back_r <= start_back;
			blocks_r <= start_blocks;
		end else begin
			if (block_end) begin
				blocks_r <= blocks_r - 1'b1; // R9
			end
			if (blocks_r == '0 && !word_full_r && !out_valid_r) begin
				active_r <= 1'b0; // R9
			end
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			shift_r <= '0;
			grp_r <= '0;
			word_r <= '0;
			word_full_r <= 1'b0;
		end else if (start) begin
			shift_r <= '0;
			grp_r <= '0;
			word_full_r <= 1'b0;
		end else begin
			if (asm_in && word_done) begin
				word_r <= shift_in; // R1 R8
				word_full_r <= 1'b1;
				shift_r <= '0;
				grp_r <= '0;
			end else if (asm_in) begin
				shift_r <= shift_in; // R5
				grp_r <= grp_r + 1'b1;
			end else if (load_shift) begin
				shift_r <= word_r; // R11
				grp_r <= 3'(`IOP_GROUPS);
				word_full_r <= 1'b0;
			end else if (send) begin
				shift_r <= {shift_r[35:0], 12'h000}; // R2 R11
				grp_r <= grp_r - 1'b1;
			end
			// Service stands apart from the shift chain so that a group arriving with it is not lost.
			if (svc) begin
				word_r <= is_out ? svc_word : '0; // R19
				word_full_r <= is_out;
			end
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			out_valid_r <= 1'b0;
			out_r <= '0;
			sprocket_r <= 1'b0;
			mark_r <= 1'b0;
		end else begin
			if (send) begin
				out_r <= {~^hi_ch, hi_ch, ~^lo_ch, lo_ch}; // R12
				out_valid_r <= 1'b1;
			end else if (out_fire || start) begin
				out_valid_r <= 1'b0;
			end
			sprocket_r <= out_fire; // R14
			mark_r <= out_fire && last_xfer; // R14
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			xcnt_r <= '0;
			chan_r <= '0;
			char_err_r <= 1'b0;
			chan_err_r <= 1'b0;
		end else begin
			if (start) begin
				xcnt_r <= '0;
				chan_r <= '0;
			end else if (asm_in || out_fire) begin
				xcnt_r <= last_xfer ? '0 : xcnt_r + 1'b1;
				chan_r <= (last_xfer || out_fire) ? '0 : chan_r ^ in_data; // R6
			end
			// A new fault in the cycle of a start still sets its flag.
			char_err_r <= (char_err_r && !start) || (in_take && !par_ok); // R5 R13
			chan_err_r <= (chan_err_r && !start) || (asm_in && last_xfer && (chan_r ^ in_data) != '0); // R6
		end
	end
endmodule : iop_assembler

// ----------------------------------------------------------------
// Top: order acceptance, memory multiplexer, assemblers
// ----------------------------------------------------------------
module iop_word_assembler_mux #(
	parameter int NUM_ASM = `IOP_NUM_ASM,
	parameter int FIFO_DEPTH = `IOP_FIFO_DEPTH,
	parameter int BLOCK_XFERS = `IOP_BLOCK_XFERS,
	parameter int POLL_STEP = `IOP_POLL_STEP_CYC
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Transfer order from the computer
	input wire logic order_valid,
	input wire logic [`IOP_UNIT_W-1:0] order_unit,
	input wire iop_pkg::iop_dir_type order_dir,
	input wire logic order_back,
	input wire logic [`IOP_BLK_W-1:0] order_blocks,
	input wire logic unit_ready,
	output logic order_continue,
	output logic order_reject,
	// Memory port through the shared transfer register
	output logic mem_req,
	input wire logic mem_avail,
	input wire logic xfer_loaded,
	input wire logic [`IOP_WORD_W-1:0] xfer_in,
	output logic [`IOP_WORD_W-1:0] xfer_out,
	output logic [$clog2(NUM_ASM)-1:0] mem_asm,
	output logic mem_dir,
	// Device side through the connecting matrix
	input wire logic [NUM_ASM-1:0] dev_in_valid,
	input wire logic [NUM_ASM*`IOP_XFER_W-1:0] dev_in_data,
	output logic [NUM_ASM-1:0] dev_in_ready,
	output logic [NUM_ASM-1:0] dev_out_valid,
	output logic [NUM_ASM*`IOP_XFER_W-1:0] dev_out_data,
	input wire logic [NUM_ASM-1:0] dev_out_ready,
	output logic [NUM_ASM-1:0] sprocket,
	output logic [NUM_ASM-1:0] block_mark,
	// Status
	output logic [NUM_ASM-1:0] asm_busy,
	output logic [NUM_ASM*`IOP_UNIT_W-1:0] asm_unit,
	output logic [NUM_ASM-1:0] char_err,
	output logic [NUM_ASM-1:0] chan_err
);
	import iop_pkg::*;
	localparam int IW = $clog2(NUM_ASM);
	iop_mux_state_type state_r;
	logic [IW-1:0] scan_r, sel_r, match_idx, free_idx;
	logic [15:0] poll_r;
	logic [`IOP_UNIT_W-1:0] unit_r [NUM_ASM];
	logic [NUM_ASM-1:0] held_r, adir_r, need, start_v, svc_v;
	logic [`IOP_WORD_W-1:0] word_v [NUM_ASM];
	logic match_any, match_busy, free_any, cont_r, rej_r, mdir_r;
	logic [`IOP_WORD_W-1:0] xout_r;

	// Lowest index wins because the loop runs downward.
	always_comb begin
		match_any = 1'b0;
		match_busy = 1'b0;
		free_any = 1'b0;
		match_idx = '0;
		free_idx = '0;
		for (int i = NUM_ASM - 1; i >= 0; i--) begin
			if (held_r[i] && unit_r[i] == order_unit) begin
				match_any = 1'b1;
				match_busy = asm_busy[i];
				match_idx = IW'(i);
			end
			if (!asm_busy[i]) begin
				free_any = 1'b1;
				free_idx = IW'(i); // R22
			end
		end
	end

	wire [IW-1:0] pick = match_any ? match_idx : free_idx;
	wire accept = order_valid && unit_ready && (match_any ? !match_busy : free_any); // R4
	wire step = poll_r == 16'(POLL_STEP - 1);
	wire [IW-1:0] after_sel = (sel_r == IW'(NUM_ASM - 1)) ? '0 : sel_r + 1'b1;
	wire [IW-1:0] after_scan = (scan_r == IW'(NUM_ASM - 1)) ? '0 : scan_r + 1'b1;
	wire done = state_r == IOP_MX_LOAD && xfer_loaded;

	assign start_v = accept ? NUM_ASM'(1) << pick : '0;
	assign svc_v = done ? NUM_ASM'(1) << sel_r : '0; // R19
	assign order_continue = cont_r;
	assign order_reject = rej_r;
	assign mem_req = state_r != IOP_MX_SCAN; // R17
	assign xfer_out = xout_r;
	assign mem_asm = sel_r;
	assign mem_dir = mdir_r;

	// The continue answer comes one cycle after the order, far inside the acceptance limit.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cont_r <= 1'b0;
			rej_r <= 1'b0;
			held_r <= '0;
			adir_r <= '0;
		end else begin
			cont_r <= accept; // R4 R21
			rej_r <= order_valid && !accept;
			if (accept) begin
				held_r[pick] <= 1'b1;
				adir_r[pick] <= order_dir;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (accept) begin
			unit_r[pick] <= order_unit;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state_r <= IOP_MX_SCAN;
			scan_r <= '0;
			sel_r <= '0;
			poll_r <= '0;
			xout_r <= '0;
			mdir_r <= 1'b0;
		end else begin
			unique case (state_r)
				IOP_MX_SCAN: begin
					if (need[scan_r]) begin
						state_r <= IOP_MX_WAIT; // R16
						sel_r <= scan_r;
						xout_r <= word_v[scan_r];
						mdir_r <= adir_r[scan_r];
						poll_r <= '0;
					end else begin
						poll_r <= step ? '0 : poll_r + 1'b1;
						scan_r <= step ? after_scan : scan_r; // R16 R23
					end
				end
				IOP_MX_WAIT: begin
					if (mem_avail) begin
						state_r <= IOP_MX_LOAD; // R17
					end
				end
				IOP_MX_LOAD: begin
					if (xfer_loaded) begin
						state_r <= IOP_MX_SCAN;
						scan_r <= after_sel; // R18 R23
					end
				end
				default: begin
					state_r <= IOP_MX_SCAN;
				end
			endcase
		end
	end

	for (genvar g = 0; g < NUM_ASM; g++) begin : g_asm
		logic f_valid, f_ready;
		logic [`IOP_XFER_W-1:0] f_data;
		assign asm_unit[g*`IOP_UNIT_W +: `IOP_UNIT_W] = held_r[g] ? unit_r[g] : '0;

		iop_fifo #(.WIDTH(`IOP_XFER_W), .DEPTH(FIFO_DEPTH)) u_fifo (
			.clk(clk),
			.reset_n(reset_n),
			.in_valid(dev_in_valid[g]),
			.in_data(dev_in_data[g*`IOP_XFER_W +: `IOP_XFER_W]),
			.in_ready(dev_in_ready[g]),
			.out_valid(f_valid),
			.out_data(f_data),
			.out_ready(f_ready)
		);

		iop_assembler #(.BLOCK_XFERS(BLOCK_XFERS)) u_asm ( // R3
			.clk(clk),
			.reset_n(reset_n),
			.start(start_v[g]),
			.start_dir(order_dir),
			.start_back(order_back),
			.start_blocks(order_blocks),
			.svc(svc_v[g]),
			.svc_word(xfer_in),
			.mem_need(need[g]),
			.word_out(word_v[g]),
			.in_valid(f_valid),
			.in_data(f_data),
			.in_ready(f_ready),
			.out_valid(dev_out_valid[g]),
			.out_data(dev_out_data[g*`IOP_XFER_W +: `IOP_XFER_W]),
			.out_ready(dev_out_ready[g]),
			.busy(asm_busy[g]),
			.sprocket(sprocket[g]),
			.block_mark(block_mark[g]),
			.char_err(char_err[g]),
			.chan_err(chan_err[g])
		);
	end
endmodule : iop_word_assembler_mux

// file: bench/iop_word_assembler_mux_props.sv
// Port checker of the word assembler and multiplexer top.
`include "iop_consts.svh"

module iop_word_assembler_mux_props #(
	parameter int NUM_ASM = `IOP_NUM_ASM
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Orders
	input wire logic order_valid,
	input wire logic unit_ready,
	input wire logic order_continue,
	input wire logic order_reject,
	// Memory port
	input wire logic mem_req,
	input wire logic xfer_loaded,
	input wire logic [$clog2(NUM_ASM)-1:0] mem_asm,
	input wire logic mem_dir,
	// Device side
	input wire logic [NUM_ASM-1:0] dev_out_valid,
	input wire logic [NUM_ASM*`IOP_XFER_W-1:0] dev_out_data,
	input wire logic [NUM_ASM-1:0] dev_out_ready,
	input wire logic [NUM_ASM-1:0] sprocket,
	input wire logic [NUM_ASM-1:0] block_mark,
	input wire logic [NUM_ASM-1:0] asm_busy
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!reset_n);

	chk_order_answered: assert property (order_valid |=> order_continue != order_reject)
		else $error("order not answered in the next cycle");
	chk_reject_unready: assert property (order_valid && !unit_ready |=> order_reject)
		else $error("order to an unready unit not refused");
	chk_answer_cause: assert property ((order_continue || order_reject) |-> $past(order_valid))
		else $error("answer without an order");
	chk_continue_busy: assert property (order_continue |-> asm_busy != '0)
		else $error("continue without a connected assembler");
	chk_req_held: assert property (mem_req && !xfer_loaded |=> mem_req && $stable(mem_asm) && $stable(mem_dir))
		else $error("memory request dropped or changed before service");
	chk_out_hold: assert property (dev_out_valid[0] && !dev_out_ready[0] |=> dev_out_valid[0] && $stable(dev_out_data[13:0]))
		else $error("output transfer changed while stalled");
	chk_out_parity: assert property (dev_out_valid[0] |-> (^dev_out_data[13:7]) && (^dev_out_data[6:0]))
		else $error("output character without odd parity");
	chk_sprocket_each: assert property (sprocket[0] == $past(dev_out_valid[0] && dev_out_ready[0]))
		else $error("sprocket not one cycle after an output transfer");
	chk_mark_sprocket: assert property (block_mark[0] |-> sprocket[0])
		else $error("block mark away from a sprocket");
endmodule : iop_word_assembler_mux_props

// file: bench/iop_partner.sv
// Memory port of the computer and a stalling output unit.
module iop_partner (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Memory port
	input wire logic mem_req,
	input wire logic mem_dir,
	input wire logic [47:0] xfer_out,
	input wire logic [47:0] fetch_word,
	output logic mem_avail,
	output logic xfer_loaded,
	output logic [47:0] xfer_in,
	output logic [47:0] stored_word,
	output logic stored_dir,
	output int served,
	// Output unit
	output logic out_ready
);
	timeunit 1ns;
	timeprecision 100ps;
	int slow = 0;

	initial begin
		mem_avail = 1'b0;
		xfer_loaded = 1'b0;
		xfer_in = 48'h0;
		out_ready = 1'b0;
		served = 0;
	end

	// Grants alternate between prompt and slow so that assembly must go on meanwhile.
	always begin
		@(posedge clk);
		#2;
		if (reset_n && mem_req) begin
			#(25 * slow);
			slow = 5 - slow;
			mem_avail = 1'b1;
			stored_word = xfer_out;
			stored_dir = mem_dir;
			#25;
			mem_avail = 1'b0;
			xfer_loaded = 1'b1;
			xfer_in = fetch_word;
			#25;
			xfer_loaded = 1'b0;
			xfer_in = ~fetch_word;
			served++;
		end
	end

	always @(posedge clk) begin
		#2;
		out_ready = ~out_ready;
	end
endmodule : iop_partner

// file: bench/iop_word_assembler_mux_tb.sv
// Self-checking bench of the word assembler and multiplexer.
`include "iop_consts.svh"

`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin bad_count++; \
	$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp); end end

module iop_word_assembler_mux_tb;
	timeunit 1ns;
	timeprecision 100ps;
	import iop_pkg::*;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic order_valid = 1'b0;
	logic order_back = 1'b0;
	logic unit_ready = 1'b1;
	logic [5:0] order_unit = 6'h00;
	logic [4:0] order_blocks = 5'h00;
	iop_dir_type order_dir = IOP_DIR_IN;
	logic [47:0] fetch_word = 48'h0;
	logic [3:0] dev_in_valid = 4'h0;
	logic [55:0] dev_in_data = 56'h0;
	logic order_continue, order_reject, mem_req, mem_avail, xfer_loaded, mem_dir, stored_dir, out_ready0;
	logic [47:0] xfer_in, xfer_out, stored_word;
	logic [1:0] mem_asm, last_asm;
	logic [3:0] dev_in_ready, dev_out_valid, dev_out_ready, sprocket, block_mark, asm_busy, char_err, chan_err;
	logic [55:0] dev_out_data;
	logic [23:0] asm_unit;
	logic [13:0] outs [0:7];
	logic [11:0] dat [0:3] = '{12'h123, 12'h456, 12'h789, 12'h2FC};
	int served, bad_count = 0, num_checks = 0, n_out = 0, n_spr = 0, n_mark = 0;

	assign dev_out_ready = {3'h7, out_ready0};

	iop_word_assembler_mux #(.BLOCK_XFERS(4), .POLL_STEP(1)) iop_word_assembler_mux_inst (
		.clk(clk), .reset_n(reset_n), .order_valid(order_valid), .order_unit(order_unit), .order_dir(order_dir),
		.order_back(order_back), .order_blocks(order_blocks), .unit_ready(unit_ready),
		.order_continue(order_continue), .order_reject(order_reject), .mem_req(mem_req), .mem_avail(mem_avail),
		.xfer_loaded(xfer_loaded), .xfer_in(xfer_in), .xfer_out(xfer_out), .mem_asm(mem_asm), .mem_dir(mem_dir),
		.dev_in_valid(dev_in_valid), .dev_in_data(dev_in_data), .dev_in_ready(dev_in_ready),
		.dev_out_valid(dev_out_valid), .dev_out_data(dev_out_data), .dev_out_ready(dev_out_ready),
		.sprocket(sprocket), .block_mark(block_mark), .asm_busy(asm_busy), .asm_unit(asm_unit),
		.char_err(char_err), .chan_err(chan_err));

	iop_partner iop_partner_inst (
		.clk(clk), .reset_n(reset_n), .mem_req(mem_req), .mem_dir(mem_dir), .xfer_out(xfer_out),
		.fetch_word(fetch_word), .mem_avail(mem_avail), .xfer_loaded(xfer_loaded), .xfer_in(xfer_in),
		.stored_word(stored_word), .stored_dir(stored_dir), .served(served), .out_ready(out_ready0));

	initial begin
		forever #12.5 clk = ~clk;
	end

	// Transfers are recorded at the falling edge, where valid and ready have settled.
	always @(negedge clk) begin
		if (reset_n && dev_out_valid[0] && out_ready0) begin
			if (n_out < 8) begin
				outs[n_out] = dev_out_data[13:0];
			end
			n_out++;
		end
		n_spr += (reset_n && sprocket[0]) ? 1 : 0;
		n_mark += (reset_n && block_mark[0]) ? 1 : 0;
		if (mem_avail) begin
			last_asm = mem_asm;
		end
	end

	function automatic logic [13:0] enc(input logic [11:0] d, input logic bad);
		return {~^d[11:6] ^ bad, d[11:6], ~^d[5:0], d[5:0]};
	endfunction : enc

	task automatic end_sim();
		$display("Comparisons %0d, mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : end_sim

	task automatic give_order(input logic [5:0] unit, input iop_dir_type dir, input logic back, input logic ok,
		input logic [4:0] blocks = 5'h01);
		@(posedge clk);
		#2;
		order_valid = 1'b1;
		order_unit = unit;
		order_dir = dir;
		order_back = back;
		order_blocks = blocks;
		@(posedge clk);
		#2;
		order_valid = 1'b0;
		order_unit = ~unit;
		`CHK(order_continue, ok)
		`CHK(order_reject, !ok)
	endtask : give_order

	task automatic send_in(input int k, input logic [11:0] d, input logic bad);
		int i;
		i = 0;
		@(posedge clk);
		#2;
		dev_in_valid[k] = 1'b1;
		dev_in_data[k*14 +: 14] = enc(d, bad);
		do begin
			@(negedge clk);
			i++;
		end while (!dev_in_ready[k] && i < 400);
		if (i >= 400) begin
			`CHK(dev_in_ready[k], 1'b1)
			end_sim();
		end
		@(posedge clk);
		#2;
		dev_in_valid[k] = 1'b0;
		dev_in_data[k*14 +: 14] = ~enc(d, bad);
	endtask : send_in

	task automatic wait_served(input int n);
		int i;
		for (i = 0; i < 2000 && served < n; i++) begin
			@(negedge clk);
		end
		if (served < n) begin
			`CHK(served, n)
			end_sim();
		end
	endtask : wait_served

	task automatic wait_idle(input int k);
		int i;
		for (i = 0; i < 2000 && asm_busy[k] !== 1'b0; i++) begin
			@(negedge clk);
		end
		if (asm_busy[k] !== 1'b0) begin
			`CHK(asm_busy[k], 1'b0)
			end_sim();
		end
	endtask : wait_idle

	task automatic s_reject();
		unit_ready = 1'b0;
		give_order(6'h05, IOP_DIR_IN, 1'b0, 1'b0);
		unit_ready = 1'b1;
		`CHK(asm_busy, 4'h0)
	endtask : s_reject

	task automatic s_input();
		int j;
		give_order(6'h05, IOP_DIR_IN, 1'b0, 1'b1);
		give_order(6'h06, IOP_DIR_IN, 1'b1, 1'b1);
		`CHK(asm_busy, 4'h3)
		`CHK(asm_unit, 24'h000185)
		for (j = 0; j < 4; j++) begin
			send_in(0, dat[j], 1'b0);
		end
		wait_served(1);
		`CHK(last_asm, 2'h0)
		`CHK(stored_word, 48'h1234567892FC)
		`CHK(stored_dir, 1'b0)
		for (j = 0; j < 4; j++) begin
			send_in(1, dat[j], 1'b0);
		end
		wait_served(2);
		`CHK(last_asm, 2'h1)
		`CHK(stored_word, 48'h2FC789456123)
		wait_idle(0);
		wait_idle(1);
		`CHK(char_err, 4'h0)
		`CHK(chan_err, 4'h0)
	endtask : s_input

	task automatic s_reuse_bad();
		int j;
		give_order(6'h06, IOP_DIR_IN, 1'b0, 1'b1);
		`CHK(asm_busy, 4'h2)
		for (j = 0; j < 4; j++) begin
			send_in(1, dat[j], j == 2);
		end
		wait_served(3);
		wait_idle(1);
		`CHK(char_err, 4'h2)
		`CHK(chan_err, 4'h2)
	endtask : s_reuse_bad

	task automatic s_output();
		int j;
		fetch_word = 48'hA5C30F1E7B29;
		n_out = 0;
		n_spr = 0;
		n_mark = 0;
		give_order(6'h09, IOP_DIR_OUT, 1'b0, 1'b1, 5'h02);
		`CHK(asm_busy, 4'h1)
		give_order(6'h09, IOP_DIR_OUT, 1'b0, 1'b0);
		send_in(0, dat[0], 1'b1);
		wait_served(5);
		`CHK(stored_dir, 1'b1)
		wait_idle(0);
		repeat (4) @(posedge clk);
		`CHK(n_out, 8)
		for (j = 0; j < 8; j++) begin
			`CHK(outs[j], enc(fetch_word[47-12*(j%4) -: 12], 1'b0))
		end
		`CHK(n_spr, 8)
		`CHK(n_mark, 2)
		`CHK(char_err, 4'h3)
		`CHK(chan_err, 4'h2)
	endtask : s_output

	initial begin
		repeat (20) @(posedge clk);
		#2;
		reset_n = 1'b1;
		s_reject();
		s_input();
		s_reuse_bad();
		s_output();
		end_sim();
	end
endmodule : iop_word_assembler_mux_tb

bind iop_word_assembler_mux iop_word_assembler_mux_props #(.NUM_ASM(NUM_ASM)) iop_word_assembler_mux_props_inst (
	.clk(clk), .reset_n(reset_n), .order_valid(order_valid), .unit_ready(unit_ready),
	.order_continue(order_continue), .order_reject(order_reject), .mem_req(mem_req), .xfer_loaded(xfer_loaded),
	.mem_asm(mem_asm), .mem_dir(mem_dir), .dev_out_valid(dev_out_valid), .dev_out_data(dev_out_data),
	.dev_out_ready(dev_out_ready), .sprocket(sprocket), .block_mark(block_mark), .asm_busy(asm_busy));
